/* rtl/tbid_map.svh */
// Register-file addresses, field positions, reset values, timing phase and register port offsets of the instruction decoder.
// Assumes nothing; it is included by the package and the core.
`ifndef TBID_MAP_SVH
`define TBID_MAP_SVH
// ==================================================
// File register addresses
`define TBID_F_INDIRECT 5'h00
`define TBID_F_TIMER0 5'h01
`define TBID_F_PC_LOW 5'h02
`define TBID_F_STATUS 5'h03
`define TBID_F_PORT_FIRST 5'h05
`define TBID_F_PORT_LAST 5'h07
// ==================================================
// Status and option fields
`define TBID_ST_CARRY 0
`define TBID_ST_DIGIT 1
`define TBID_ST_ZERO 2
`define TBID_ST_PWRDN 3
`define TBID_ST_TIMEOUT 4
`define TBID_OPT_PRESC_ASSIGN 3
// ==================================================
// Reset values
`define TBID_RST_STATUS 8'h18
`define TBID_RST_OPTION 8'h3f
`define TBID_RST_DIRECTION 8'hff
`define TBID_RST_PC 9'h1ff
// ==================================================
// Timing: last oscillator phase of the four-period instruction cycle
`define TBID_PHASE_LAST 2'h3
// ==================================================
// Register port offsets beyond the file registers
`define TBID_BUS_ACC 6'h20
`define TBID_BUS_OPTION 6'h21
`define TBID_BUS_PC_LOW 6'h22
`define TBID_BUS_STATE 6'h23
`endif

/* rtl/tbid_pkg.sv */
// Types of the instruction decoder: instruction fields, port vectors and operations.
// Assumes the map header for the file addresses it decodes.
`include "tbid_map.svh"
package tbid_pkg;
  typedef struct packed {
    logic [3:0] grp;
    logic [2:0] bsel;
    logic [4:0] fsel;
  } tbid_instr_t;

  typedef logic [2:0][7:0] tbid_port_t;

  typedef enum {
    op_nop, op_add_acc_to_file, op_and_acc_with_file, op_or_acc_with_file, op_xor_acc_with_file,
    op_sub_acc_from_file, op_clear_file, op_clear_acc, op_complement, op_decrement, op_decrement_skip_zero,
    op_increment, op_increment_skip_zero, op_move_file, op_move_acc_to_file, op_rotate_left_carry,
    op_rotate_right_carry, op_swap_nibbles, op_bit_clear_op, op_bit_set_op, op_bit_test_skip_clear,
    op_bit_test_skip_set, op_and_literal_acc, op_or_literal_acc, op_xor_literal_acc, op_move_literal,
    op_call, op_jump, op_return_with_literal, op_watchdog_clear, op_load_option, op_standby,
    op_direction_latch_load
  } tbid_op_t;

  function automatic tbid_op_t tbid_decode(input logic [11:0] w);
    casez (w)
      12'b0001_11??_????: return op_add_acc_to_file;
      12'b0001_01??_????: return op_and_acc_with_file;
      12'b0001_00??_????: return op_or_acc_with_file;
      12'b0001_10??_????: return op_xor_acc_with_file;
      12'b0000_10??_????: return op_sub_acc_from_file;
      12'b0000_011?_????: return op_clear_file;
      12'b0000_0100_0000: return op_clear_acc;
      12'b0010_01??_????: return op_complement;
      12'b0000_11??_????: return op_decrement;
      12'b0010_11??_????: return op_decrement_skip_zero;
      12'b0010_10??_????: return op_increment;
      12'b0011_11??_????: return op_increment_skip_zero;
      12'b0010_00??_????: return op_move_file;
      12'b0000_001?_????: return op_move_acc_to_file;
      12'b0011_01??_????: return op_rotate_left_carry;
      12'b0011_00??_????: return op_rotate_right_carry;
      12'b0011_10??_????: return op_swap_nibbles;
      12'b0100_????_????: return op_bit_clear_op;
      12'b0101_????_????: return op_bit_set_op;
      12'b0110_????_????: return op_bit_test_skip_clear;
      12'b0111_????_????: return op_bit_test_skip_set;
      12'b1110_????_????: return op_and_literal_acc;
      12'b1101_????_????: return op_or_literal_acc;
      12'b1111_????_????: return op_xor_literal_acc;
      12'b1100_????_????: return op_move_literal;
      12'b1001_????_????: return op_call;
      12'b101?_????_????: return op_jump;
      12'b1000_????_????: return op_return_with_literal;
      12'b0000_0000_0100: return op_watchdog_clear;
      12'b0000_0000_0010: return op_load_option;
      12'b0000_0000_0011: return op_standby;
      12'b0000_0000_0101, 12'b0000_0000_0110, 12'b0000_0000_0111: return op_direction_latch_load;
      default: return op_nop;
    endcase
  endfunction
endpackage

/* rtl/tbid_core.sv */
// Decode-and-execute core for 12-bit instruction words, with its own 32-entry file register array.
// Assumes program memory returns INSTR for PC_ADDR before the end of each instruction cycle,
// and that all inputs are synchronous to CLK_SYS.
`timescale 1ns/1ps
`include "tbid_map.svh"
module tbid_core import tbid_pkg::*; (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  // Program memory
  input wire logic [11:0] INSTR,
  output logic [8:0] PC_ADDR,
  // I/O ports: pins in, latches out, enable low drives
  input wire tbid_port_t PORT_IN,
  output tbid_port_t PORT_OUT,
  output tbid_port_t PORT_OE_N,
  // Side effects towards timer and watchdog
  output logic PRESCALER_CLR,
  output logic WDT_CLR,
  output logic STANDBY,
  // Register port
  input wire logic [5:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA
);
  // ==================================================
  // Instruction cycle divider
  logic [1:0] phase;
  logic exec;
  logic flush;
  logic live;
  assign exec = (phase == `TBID_PHASE_LAST) && !STANDBY;
  assign live = exec && !flush;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // ==================================================
  // Decode
  tbid_instr_t iw;
  tbid_op_t op;
  logic [4:0] f;
  logic d;
  logic [7:0] k;
  logic [7:0] file_q [0:31];
  logic [7:0] acc;
  logic [7:0] option;
  logic [8:0] stack0;
  logic [8:0] stack1;
  logic [7:0] status;
  logic is_port;
  logic [1:0] pidx;
  logic [7:0] src;
  assign iw = tbid_instr_t'(INSTR);
  assign op = tbid_decode(INSTR);
  assign f = iw.fsel;
  assign d = iw.bsel[0];
  assign k = {iw.bsel, iw.fsel};
  assign status = file_q[`TBID_F_STATUS];
  assign is_port = (f >= `TBID_F_PORT_FIRST) && (f <= `TBID_F_PORT_LAST);
  assign pidx = 2'(f - `TBID_F_PORT_FIRST);
  assign src = is_port ? PORT_IN[pidx] : (f == `TBID_F_PC_LOW) ? PC_ADDR[7:0] :
               (f == `TBID_F_INDIRECT) ? 8'h00 : file_q[f];

  // ==================================================
  // Arithmetic and logic
  logic [8:0] sum;
  logic [8:0] diff;
  logic [7:0] res;
  logic byte_op;
  logic wr_file;
  logic wr_acc;
  logic upd_z;
  logic upd_cdc;
  logic new_c;
  logic new_digit;
  logic skip;
  logic bit_val;
  assign sum = {1'b0, acc} + {1'b0, src};
  assign diff = {1'b0, src} - {1'b0, acc};
  assign bit_val = src[iw.bsel];

  always_comb begin
    res = 8'h00;
    new_c = status[`TBID_ST_CARRY];
    new_digit = status[`TBID_ST_DIGIT];
    unique case (op)
      op_add_acc_to_file: begin
        res = sum[7:0];
        new_c = sum[8];
        new_digit = (5'({1'b0, acc[3:0]}) + 5'({1'b0, src[3:0]})) > 5'h0f;
      end
      op_sub_acc_from_file: begin
        res = diff[7:0];
        new_c = !diff[8];
        new_digit = src[3:0] >= acc[3:0];
      end
      op_and_acc_with_file: res = acc & src;
      op_or_acc_with_file: res = acc | src;
      op_xor_acc_with_file: res = acc ^ src;
      op_complement: res = ~src;
      op_decrement, op_decrement_skip_zero: res = src - 8'h01;
      op_increment, op_increment_skip_zero: res = src + 8'h01;
      op_move_file: res = src;
      op_move_acc_to_file: res = acc;
      op_rotate_left_carry: begin
        res = {src[6:0], status[`TBID_ST_CARRY]};
        new_c = src[7];
      end
      op_rotate_right_carry: begin
        res = {status[`TBID_ST_CARRY], src[7:1]};
        new_c = src[0];
      end
      op_swap_nibbles: res = {src[3:0], src[7:4]};
      op_bit_clear_op: res = src & ~(8'h01 << iw.bsel);
      op_bit_set_op: res = src | (8'h01 << iw.bsel);
      op_and_literal_acc: res = acc & k;
      op_or_literal_acc: res = acc | k;
      op_xor_literal_acc: res = acc ^ k;
      op_move_literal, op_return_with_literal: res = k;
      default: res = 8'h00;
    endcase
  end

  assign byte_op = (INSTR[11:10] == 2'b00) && !(op inside {op_nop, op_clear_acc, op_watchdog_clear,
                   op_load_option, op_standby, op_direction_latch_load});
  assign wr_file = (byte_op && (d || op inside {op_clear_file, op_move_acc_to_file}))
                   || (op inside {op_bit_clear_op, op_bit_set_op});
  assign wr_acc = (byte_op && !d && !(op inside {op_clear_file, op_move_acc_to_file}))
                  || (op inside {op_clear_acc, op_and_literal_acc, op_or_literal_acc, op_xor_literal_acc,
                      op_move_literal, op_return_with_literal});
  assign upd_z = op inside {op_add_acc_to_file, op_sub_acc_from_file, op_and_acc_with_file,
                 op_or_acc_with_file, op_xor_acc_with_file, op_clear_file, op_clear_acc, op_complement,
                 op_decrement, op_increment, op_move_file, op_and_literal_acc, op_or_literal_acc,
                 op_xor_literal_acc};
  assign upd_cdc = op inside {op_add_acc_to_file, op_sub_acc_from_file};
  assign skip = ((op inside {op_decrement_skip_zero, op_increment_skip_zero}) && (res == 8'h00))
                || (op == op_bit_test_skip_clear && !bit_val) || (op == op_bit_test_skip_set && bit_val);

  // ==================================================
  // Status merge: a file write to status is overlaid by flag updates
  logic [7:0] next_status;
  always_comb begin
    next_status = (wr_file && f == `TBID_F_STATUS) ? res : status;
    if (upd_z) begin
      next_status[`TBID_ST_ZERO] = (res == 8'h00);
    end
    if (upd_cdc || op inside {op_rotate_left_carry, op_rotate_right_carry}) begin
      next_status[`TBID_ST_CARRY] = new_c;
    end
    if (upd_cdc) begin
      next_status[`TBID_ST_DIGIT] = new_digit;
    end
    if (op inside {op_standby, op_watchdog_clear}) begin
      next_status[`TBID_ST_TIMEOUT] = 1'b1;
      next_status[`TBID_ST_PWRDN] = (op == op_watchdog_clear);
    end
  end

  // ==================================================
  // Program counter
  logic pc_write;
  logic [8:0] next_pc;
  assign pc_write = op inside {op_call, op_jump, op_return_with_literal}
                    || (wr_file && f == `TBID_F_PC_LOW);
  // ninth bit forced low on call, return and PC file writes; jump loads it and increments carry into it
  assign next_pc = (op == op_jump) ? INSTR[8:0] :
                   (op == op_call) ? {1'b0, k} :
                   (op == op_return_with_literal) ? {1'b0, stack0[7:0]} :
                   pc_write ? {1'b0, res} :
                   skip ? PC_ADDR + 9'h002 : PC_ADDR + 9'h001;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      PC_ADDR <= `TBID_RST_PC;
      flush <= 1'b0;
      stack0 <= 9'h000;
      stack1 <= 9'h000;
    end else if (exec) begin
      flush <= live && (skip || pc_write);
      if (live) begin
        PC_ADDR <= next_pc;
        if (op == op_call) begin
          stack1 <= stack0;
          stack0 <= PC_ADDR + 9'h001;
        end else if (op == op_return_with_literal) begin
          stack0 <= stack1;
        end
      end
    end
  end

  // ==================================================
  // Accumulator, file array, option and direction latches
  logic bus_file_wr;
  logic [2:0] direction_latch_load_sel;
  assign bus_file_wr = WR && !ADDR[5] && !(live && wr_file);
  assign direction_latch_load_sel = 3'(INSTR[2:0] - 3'h5);

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      acc <= 8'h00;
      option <= `TBID_RST_OPTION;
      PORT_OE_N <= {3{`TBID_RST_DIRECTION}};
      for (int i = 0; i < 32; i++) begin
        file_q[i] <= (i == `TBID_F_STATUS) ? `TBID_RST_STATUS : 8'h00;
      end
    end else begin
      if (live && wr_acc) begin
        acc <= res;
      end else if (WR && ADDR == `TBID_BUS_ACC) begin
        acc <= WDATA;
      end
      if (live && op == op_load_option) begin
        option <= acc;
      end
      if (live && op == op_direction_latch_load) begin
        PORT_OE_N[direction_latch_load_sel[1:0]] <= acc;
      end
      if (live && wr_file) begin
        file_q[f] <= res;
      end else if (bus_file_wr) begin
        file_q[ADDR[4:0]] <= WDATA;
      end
      if (live) begin
        file_q[`TBID_F_STATUS] <= next_status;
      end
    end
  end

  // ==================================================
  // Outputs and side-effect pulses
  logic [7:0] rd_mux;
  assign rd_mux = !ADDR[5] ? file_q[ADDR[4:0]] :
                  (ADDR == `TBID_BUS_ACC) ? acc :
                  (ADDR == `TBID_BUS_OPTION) ? option :
                  (ADDR == `TBID_BUS_PC_LOW) ? PC_ADDR[7:0] :
                  (ADDR == `TBID_BUS_STATE) ? {6'h00, flush, STANDBY} : 8'h00;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      PORT_OUT <= '0;
      PRESCALER_CLR <= 1'b0;
      WDT_CLR <= 1'b0;
      STANDBY <= 1'b0;
      RDATA <= 8'h00;
    end else begin
      for (int p = 0; p < 3; p++) begin
        PORT_OUT[p] <= file_q[5 + p];
      end
      PRESCALER_CLR <= live && wr_file && f == `TBID_F_TIMER0 && !option[`TBID_OPT_PRESC_ASSIGN];
      WDT_CLR <= live && (op inside {op_watchdog_clear, op_standby});
      if (live && op == op_standby) begin
        STANDBY <= 1'b1;
      end
      RDATA <= RD ? rd_mux : 8'h00;
    end
  end

  // ==================================================
  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);

  add_to_acc_a: assert property (live && op == op_add_acc_to_file && !d |=> acc == $past(sum[7:0]))
    else $error("add to accumulator wrong");
  file_dest_a: assert property (live && byte_op && d |=> acc == $past(acc))
    else $error("accumulator changed on file destination");
  logic_flags_a: assert property (live && op inside {op_and_acc_with_file, op_xor_acc_with_file} && f != 5'h03
    |=> status[1:0] == $past(status[1:0]))
    else $error("logic op touched carry");
  count_skip_a: assert property (live && op == op_decrement_skip_zero && src == 8'h01 |=> flush ##4 !flush)
    else $error("zero result did not skip once");
  rotate_zero_a: assert property (live && op == op_rotate_left_carry && f != 5'h03
    |=> status[`TBID_ST_ZERO] == $past(status[`TBID_ST_ZERO]) && status[0] == $past(src[7]))
    else $error("rotate flags wrong");
  bit_test_a: assert property (live && op == op_bit_test_skip_set && !bit_val |=> !flush)
    else $error("bit test skipped on clear bit");
  bit_clear_a: assert property (live && op == op_bit_clear_op && f != 5'h03 |=> $stable(status))
    else $error("bit clear changed status");
  literal_and_a: assert property (live && op == op_and_literal_acc |=> acc == ($past(acc) & $past(k)))
    else $error("literal and wrong");
  return_pc_a: assert property (live && op == op_return_with_literal
    |=> !PC_ADDR[8] && flush && acc == $past(k))
    else $error("return did not load and flush");
  standby_a: assert property (live && op == op_standby
    |=> STANDBY && status[4] && !status[3] ##1 STANDBY)
    else $error("standby entry wrong");
  latch_load_a: assert property (live && INSTR == 12'h006 |=> PORT_OE_N[1] == $past(acc))
    else $error("direction latch not loaded");
  prescaler_a: assert property (live && op inside {op_clear_file, op_move_acc_to_file} && f == 5'h01 && !option[3]
    |=> PRESCALER_CLR)
    else $error("prescaler not cleared");
  unlisted_a: assert property (live && INSTR == 12'h001 |=> $stable(acc) && !flush)
    else $error("unlisted word had an effect");

  skip_taken_c: cover property (live && skip ##4 flush);
  call_return_c: cover property (live && op == op_call ##[4:40] live && op == op_return_with_literal);
  port_rmw_c: cover property (live && is_port && wr_file);
  standby_c: cover property (live && op == op_standby);
endmodule // tbid_core

/* bench/tbid_far_side.sv */
// Far side of the decoder: program memory and the pins of the three I/O ports.
// Assumes the bench loads the memory array and the external pin levels directly.
`timescale 1ns/1ps
module tbid_far_side import tbid_pkg::*; (
  // Program memory
  input wire logic [8:0] pc_addr,
  output logic [11:0] instr,
  // Pins
  input wire tbid_port_t port_out,
  input wire tbid_port_t port_oe_n,
  input wire tbid_port_t ext_level,
  output tbid_port_t port_in
);
  logic [11:0] mem [0:511];
  // ==================================================
  // Memory
  // Unwritten words read as zero, the no-operation pattern
  initial begin
    foreach (mem[i]) begin
      mem[i] = 12'h000;
    end
  end
  assign instr = mem[pc_addr];
  // ==================================================
  // Pin levels
  // floating pins follow outside
  assign port_in = (port_out & ~port_oe_n) | (ext_level & port_oe_n);
endmodule // tbid_far_side

/* bench/tbid_bench.sv */
// Self-checking bench of the instruction decoder core.
// Assumes the far-side model supplies program words and resolves the port pins.
`timescale 1ns/1ps
module twelve_bit_instruction_decoder_bench import tbid_pkg::*;;
  typedef struct packed {
    logic [11:0] instr;
    logic [7:0] acc;
    logic [7:0] fin;
    logic [7:0] st;
    logic [7:0] acc_e;
    logic [7:0] f_e;
    logic [7:0] st_e;
    logic [8:0] pc_e;
  } tbid_row_t;
  logic CLK_SYS = 1'b0;
  logic ARST_N = 1'b0;
  logic [5:0] ADDR = 6'h00;
  logic [7:0] WDATA = 8'h00;
  logic WR = 1'b0;
  logic RD = 1'b0;
  tbid_port_t ext_level = {8'h00, 8'h3c, 8'h3c};
  tbid_port_t port_in;
  tbid_port_t port_out;
  tbid_port_t port_oe_n;
  logic [11:0] instr;
  logic [8:0] pc_addr;
  logic presc_clr;
  logic wdt_clr;
  logic STANDBY;
  logic [7:0] RDATA;
  int failures = 0;
  int samples_checked = 0;
  int presc_seen = 0;
  int wdt_seen = 0;
  tbid_row_t r;
  logic [5:0] fa;
  logic [7:0] v;
  // Rows: word, acc, file, status in, then acc, file, status and PC expected
  tbid_row_t rows [27] = '{
    '{12'h1c8, 8'hf1, 8'h0f, 8'h00, 8'h00, 8'h0f, 8'h1f, 9'h000},
    '{12'h1e8, 8'h17, 8'hc2, 8'h07, 8'h17, 8'hd9, 8'h18, 9'h000},
    '{12'h168, 8'h17, 8'hc2, 8'h07, 8'h17, 8'h02, 8'h1b, 9'h000},
    '{12'h128, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1c, 9'h000},
    '{12'h188, 8'h5a, 8'ha5, 8'h04, 8'hff, 8'ha5, 8'h18, 9'h000},
    '{12'h2e8, 8'h00, 8'h01, 8'h03, 8'h00, 8'h00, 8'h1b, 9'h001},
    '{12'h3c8, 8'h00, 8'h05, 8'h07, 8'h06, 8'h05, 8'h1f, 9'h000},
    '{12'h368, 8'h00, 8'h81, 8'h04, 8'h00, 8'h02, 8'h1d, 9'h000},
    '{12'h308, 8'h11, 8'h01, 8'h02, 8'h00, 8'h01, 8'h1b, 9'h000},
    '{12'h4ff, 8'h00, 8'hc7, 8'h07, 8'h00, 8'h47, 8'h1f, 9'h000},
    '{12'h608, 8'h00, 8'hfe, 8'h00, 8'h00, 8'hfe, 8'h18, 9'h001},
    '{12'h708, 8'h00, 8'hfe, 8'h00, 8'h00, 8'hfe, 8'h18, 9'h000},
    '{12'he5f, 8'ha3, 8'h00, 8'h04, 8'h03, 8'h00, 8'h18, 9'h000},
    '{12'hd00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1c, 9'h000},
    '{12'hfff, 8'h0f, 8'h00, 8'h04, 8'hf0, 8'h00, 8'h18, 9'h000},
    '{12'h001, 8'h12, 8'h34, 8'h07, 8'h12, 8'h34, 8'h1f, 9'h000},
    // Subtract: carry clear means a borrow was taken
    '{12'h088, 8'h05, 8'h03, 8'h07, 8'hfe, 8'h03, 8'h18, 9'h000},
    '{12'h068, 8'h22, 8'h77, 8'h00, 8'h22, 8'h00, 8'h1c, 9'h000},
    '{12'h040, 8'h9c, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1c, 9'h000},
    '{12'h248, 8'h00, 8'h0f, 8'h04, 8'hf0, 8'h0f, 8'h18, 9'h000},
    '{12'h0e8, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h1c, 9'h000},
    '{12'h2a8, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h1c, 9'h000},
    '{12'hc7e, 8'h00, 8'h00, 8'h04, 8'h7e, 8'h00, 8'h1c, 9'h000},
    '{12'h3a8, 8'h00, 8'h4b, 8'h07, 8'h00, 8'hb4, 8'h1f, 9'h000},
    '{12'h568, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h18, 9'h000},
    '{12'h004, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h18, 9'h000},
    '{12'h003, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 9'h000}
  };

  always #12.5 CLK_SYS = ~CLK_SYS;
  always @(posedge CLK_SYS) begin
    if (presc_clr === 1'b1) begin
      presc_seen++;
    end
    if (wdt_clr === 1'b1) begin
      wdt_seen++;
    end
  end

  tbid_core tbid_core_i (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .INSTR(instr), .PC_ADDR(pc_addr),
    .PORT_IN(port_in), .PORT_OUT(port_out), .PORT_OE_N(port_oe_n), .PRESCALER_CLR(presc_clr),
    .WDT_CLR(wdt_clr), .STANDBY(STANDBY), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA));
  tbid_far_side tbid_far_side_i (.pc_addr(pc_addr), .instr(instr), .port_out(port_out),
    .port_oe_n(port_oe_n), .ext_level(ext_level), .port_in(port_in));

  // ==================================================
  // Shared tasks
  task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Entered at a rising edge; the caller lowers the strobe after the last write
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK_SYS);
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK_SYS);
    RD <= 1'b0;
    #1;
    d = RDATA;
    @(posedge CLK_SYS);
  endtask
  // Three writes land before the first execute edge, so none collides with the core
  task automatic restart(input logic [7:0] acc, input logic [5:0] a2, input logic [7:0] v2,
                         input logic [5:0] a3, input logic [7:0] v3);
    ARST_N <= 1'b0;
    repeat (3) @(posedge CLK_SYS);
    ARST_N <= 1'b1;
    wr(6'h20, acc);
    wr(a2, v2);
    wr(a3, v3);
    WR <= 1'b0;
  endtask
  task automatic exec(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask
  task automatic load(input logic [8:0] a, input logic [11:0] w0, input logic [11:0] w1,
                      input logic [11:0] w2, input logic [11:0] w3);
    tbid_far_side_i.mem[9'h1ff] = w0;
    tbid_far_side_i.mem[a] = w1;
    tbid_far_side_i.mem[9'h001] = w2;
    tbid_far_side_i.mem[9'h002] = w3;
    @(posedge CLK_SYS);
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==================================================
  // Main sequence
  initial begin
    // No falling reset edge at time zero: the first clock edge applies the reset
    @(posedge CLK_SYS);
    #1;
    check("pc at reset", pc_addr, 12'h1ff);
    check("standby at reset", STANDBY, 12'h000);
    for (int k = 0; k < 3; k++) begin
      check("direction at reset", port_oe_n[k], 12'h0ff);
    end
    @(posedge CLK_SYS);
    foreach (rows[i]) begin
      r = rows[i];
      fa = (r.instr[11:10] == 2'b11 || r.instr[11:5] == 7'h00) ? 6'h08 : {1'b0, r.instr[4:0]};
      tbid_far_side_i.mem[9'h1ff] = r.instr;
      restart(r.acc, fa, r.fin, 6'h03, r.st | 8'h18);
      exec(1);
      check("pc", pc_addr, r.pc_e);
      @(posedge CLK_SYS);
      rd(6'h20, v);
      check("acc", v, r.acc_e);
      rd(fa, v);
      check("file", v, r.f_e);
      rd(6'h03, v);
      check("status", v, r.st_e);
    end
    check("standby", STANDBY, 12'h001);
    check("watchdog clears", 12'(wdt_seen), 12'h002);
    // Call, return and jump: flush cycles hold the PC
    load(9'h040, 12'h940, 12'h85a, 12'h000, 12'h000);
    tbid_far_side_i.mem[9'h000] = 12'hba0;
    restart(8'h00, 6'h08, 8'h00, 6'h09, 8'h00);
    exec(1);
    check("call target", pc_addr, 12'h040);
    exec(4);
    check("flush holds pc", pc_addr, 12'h040);
    exec(4);
    check("return address", pc_addr, 12'h000);
    exec(8);
    check("jump target", pc_addr, 12'h1a0);
    @(posedge CLK_SYS);
    rd(6'h20, v);
    check("return literal", v, 12'h05a);
    tbid_far_side_i.mem[9'h040] = 12'h000;
    // Direction latches, then port rewrites from the pins
    load(9'h000, 12'h007, 12'h006, 12'h225, 12'h226);
    restart(8'hf0, 6'h05, 8'hff, 6'h06, 8'ha5);
    exec(5);
    check("direction first", port_oe_n[0], 12'h0ff);
    check("direction second", port_oe_n[1], 12'h0f0);
    check("direction third", port_oe_n[2], 12'h0f0);
    // Port latches follow the file one clock after the execute edge
    exec(9);
    check("port first from pins", port_out[0], 12'h03c);
    check("port second from pins", port_out[1], 12'h035);
    // Timer writes: only one with the prescaler assigned and the file as target
    load(9'h000, 12'h021, 12'h002, 12'h0c1, 12'h021);
    restart(8'h00, 6'h08, 8'h00, 6'h09, 8'h00);
    presc_seen = 0;
    exec(18);
    check("prescaler clears", 12'(presc_seen), 12'h001);
    wrap_up();
  end

  // Whole run is well under a thousand cycles
  initial begin
    #100000;
    failures++;
    wrap_up();
  end
endmodule // twelve_bit_instruction_decoder_bench
